/* verilog/charging_port_params.svh */
// offsets, field positions, reset values and timing counts of the charging port mode control
`ifndef CHARGING_PORT_PARAMS_SVH
`define CHARGING_PORT_PARAMS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define ADDR_CONTROL        8'h00
`define ADDR_STATUS         8'h04
`define ADDR_SHORT_COUNT    8'h08

// control register fields
`define CTRL_SOFT_EN_BIT    0
`define CTRL_REG_MODE_BIT   1
`define CTRL_MODE_LSB       2
`define CTRL_FORCE_DIS_BIT  5
`define CTRL_WIDTH          5
`define CTRL_RESET          5'h01

// status register fields
`define STAT_MODE_LSB       0
`define STAT_ENABLE_BIT     3
`define STAT_CLIMIT_BIT     4
`define STAT_DATA_ON_BIT    5
`define STAT_POWER_ON_BIT   6
`define STAT_DISCHARGE_BIT  7
`define STAT_DCP_LSB        8

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_MHZ        25
`define T_1V2_US            100
`define T_1V2_CYCLES        (`T_1V2_US * `CLK_FREQ_MHZ)
`define T_DISCHARGE_US      100
`define T_DISCHARGE_CYCLES  (`T_DISCHARGE_US * `CLK_FREQ_MHZ)
`define TIMER_WIDTH         12

`endif

/* verilog/charging_port_pkg.sv */
// types and decode functions shared by the charging port mode control
package charging_port_pkg;

    // ------------------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DCP,
        MODE_CLIENT,
        MODE_SDP,
        MODE_CDP
    } port_mode_type;

    typedef enum logic [1:0] {
        DCP_DIVIDER,
        DCP_ONE_V2,
        DCP_SHORTED
    } dcp_state_type;

    // ------------------------------------------------------------------------
    // pin carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       enable;         // enable pin, active high
        logic [2:0] mode_sel;       // {mode_select_a, mode_select_b, mode_select_c}
        logic       short_detect;   // attached device answers the shorted scheme
        logic       line_held;      // attached device keeps holding the data line
        logic       current_limit;  // power switch sits in current limit
    } pin_in_type;

    typedef struct packed {
        logic power_on;             // port power switch closed
        logic data_on;              // data-line switches closed
        logic discharge;            // port output discharge active
        logic divider_drive;        // divider_three_scheme bias on both lines
        logic lines_short;          // data lines tied together
        logic pullup_1v2;           // tied lines pulled to the 1.2 V level
    } switch_out_type;

    // ------------------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------------------
    function automatic port_mode_type mode_of(input logic [2:0] sel);
        if (!sel[2]) begin
            mode_of = MODE_DCP;
        end else if (!sel[1]) begin
            mode_of = MODE_CLIENT;
        end else if (!sel[0]) begin
            mode_of = MODE_SDP;
        end else begin
            mode_of = MODE_CDP;
        end
    endfunction : mode_of

    // pattern changes that leave the port output charged
    function automatic logic quiet_change(input logic [2:0] old_sel, input logic [2:0] new_sel);
        quiet_change = (old_sel[2:1] == new_sel[2:1]) && (old_sel[2:1] != 2'b10);
    endfunction : quiet_change

endpackage : charging_port_pkg

/* verilog/mode_decode.sv */
// mode decode and data-switch enable of the charging port
`timescale 1ns/1ps

module mode_decode (
    input  wire logic                          i_enable,
    input  wire logic [2:0]                    i_mode_sel,
    input  wire logic                          i_discharge,
    input  wire logic                          i_dcp_power,
    output charging_port_pkg::port_mode_type   o_mode,
    output logic                               o_data_on,
    output logic                               o_power_on
);

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    wire charging_port_pkg::port_mode_type mode_now = charging_port_pkg::mode_of(i_mode_sel);
    wire pass_mode = (mode_now != charging_port_pkg::MODE_DCP);

    // discharge and a low enable override every mode; current limit has no say here
    assign o_mode     = mode_now;
    assign o_data_on  = i_enable && !i_discharge && pass_mode;

    // client mode blocks port power but keeps data passing
    assign o_power_on = i_enable && !i_discharge &&
                        (mode_now != charging_port_pkg::MODE_CLIENT) &&
                        ((mode_now != charging_port_pkg::MODE_DCP) || i_dcp_power);

endmodule : mode_decode

/* verilog/dcp_auto_fsm.sv */
// dedicated-charging auto-detect state machine
`timescale 1ns/1ps
`include "charging_port_params.svh"

module dcp_auto_fsm #(
    parameter int unsigned ONE_V2_CYCLES = `T_1V2_CYCLES
) (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_active,
    input  wire logic                          i_short_detect,
    input  wire logic                          i_line_held,
    output charging_port_pkg::dcp_state_type   o_state,
    output logic                               o_power_on,
    output logic                               o_enter_shorted
);

    charging_port_pkg::dcp_state_type state_reg;
    charging_port_pkg::dcp_state_type state_next;
    logic [`TIMER_WIDTH-1:0]          timer_reg;
    logic [`TIMER_WIDTH-1:0]          timer_next;

    localparam logic [`TIMER_WIDTH-1:0] ONE_V2_LOAD = `TIMER_WIDTH'(ONE_V2_CYCLES - 1);

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        case (state_reg)
            charging_port_pkg::DCP_DIVIDER: begin
                if (i_short_detect) begin
                    state_next = charging_port_pkg::DCP_ONE_V2;
                    timer_next = ONE_V2_LOAD;
                end
            end
            charging_port_pkg::DCP_ONE_V2: begin
                if (timer_reg == '0) begin
                    state_next = charging_port_pkg::DCP_SHORTED;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            charging_port_pkg::DCP_SHORTED: begin
                if (!i_line_held) begin
                    state_next = charging_port_pkg::DCP_DIVIDER;
                end
            end
            default: begin
                state_next = charging_port_pkg::DCP_DIVIDER;
            end
        endcase
        // leaving auto mode restarts detection in the divider scheme
        if (!i_active) begin
            state_next = charging_port_pkg::DCP_DIVIDER;
            timer_next = '0;
        end
    end

    // ------------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= charging_port_pkg::DCP_DIVIDER;
            timer_reg <= '0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    // power stays on through every scheme change, so no discharge is asked for
    assign o_state         = state_reg;
    assign o_power_on      = 1'b1;
    assign o_enter_shorted = (state_reg == charging_port_pkg::DCP_ONE_V2) &&
                             (state_next == charging_port_pkg::DCP_SHORTED);

endmodule : dcp_auto_fsm

/* verilog/charging_port_ctrl.sv */
// top of the charging port mode control: pin sync, registers, discharge and switch outputs
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "charging_port_params.svh"

module charging_port_ctrl #(
    parameter int unsigned ONE_V2_CYCLES    = `T_1V2_CYCLES,
    parameter int unsigned DISCHARGE_CYCLES = `T_DISCHARGE_CYCLES
) (
    input  wire logic                           i_core_clk,
    input  wire logic                           i_reset_n,
    input  wire logic [7:0]                     i_addr,
    input  wire logic [31:0]                    i_wdata,
    input  wire logic                           i_wr,
    input  wire logic                           i_rd,
    output logic [31:0]                         o_rdata,
    input  wire charging_port_pkg::pin_in_type  i_pins,
    output charging_port_pkg::switch_out_type   o_switches
);

    localparam int unsigned PIN_W = $bits(charging_port_pkg::pin_in_type);
    localparam logic [`TIMER_WIDTH-1:0] DIS_LOAD = `TIMER_WIDTH'(DISCHARGE_CYCLES - 1);

    // ------------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    // assert at once, release two edges later so no flop leaves reset mid-edge
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [PIN_W-1:0]              pin_meta_reg;
    logic [PIN_W-1:0]              pin_sync_reg;
    charging_port_pkg::pin_in_type pins;

    // the first stage feeds only the second; all logic reads the second
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= i_pins[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    assign pins = charging_port_pkg::pin_in_type'(pin_sync_reg);

    // ------------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------------
    logic [`CTRL_WIDTH-1:0] ctrl_reg;
    logic [15:0]            short_count_reg;
    logic [15:0]            short_count_next;
    logic [31:0]            rdata_reg;

    wire hit_ctrl  = (i_addr == `ADDR_CONTROL);
    wire hit_stat  = (i_addr == `ADDR_STATUS);
    wire hit_count = (i_addr == `ADDR_SHORT_COUNT);
    wire wr_ctrl   = i_wr && hit_ctrl;
    wire wr_count  = i_wr && hit_count;

    // force-discharge is a write-only strobe, never stored
    wire force_dis = wr_ctrl && i_wdata[`CTRL_FORCE_DIS_BIT];

    // ------------------------------------------------------------------------
    // effective controls
    // ------------------------------------------------------------------------
    wire       soft_en  = ctrl_reg[`CTRL_SOFT_EN_BIT];
    wire       reg_mode = ctrl_reg[`CTRL_REG_MODE_BIT];
    wire [2:0] mode_reg_sel = ctrl_reg[`CTRL_MODE_LSB +: 3];

    // the pin enable always gates; software may only take the port down further
    wire       enable_eff = pins.enable && soft_en;
    wire [2:0] mode_sel   = reg_mode ? mode_reg_sel : pins.mode_sel;

    // ------------------------------------------------------------------------
    // port output discharge
    // ------------------------------------------------------------------------
    logic [2:0]              mode_prev_reg;
    logic [`TIMER_WIDTH-1:0] dis_timer_reg;
    logic [`TIMER_WIDTH-1:0] dis_timer_next;
    logic                    discharging_reg;

    // 000/001, 010/011 and 110/111 swaps keep the output charged
    wire mode_moved  = (mode_sel != mode_prev_reg);
    wire dis_trigger = force_dis ||
                       (mode_moved && !charging_port_pkg::quiet_change(mode_prev_reg, mode_sel));

    assign dis_timer_next = dis_trigger     ? DIS_LOAD :
                            (dis_timer_reg != '0) ? dis_timer_reg - 1'b1 : '0;

    always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_prev_reg   <= 3'h0;
            dis_timer_reg   <= '0;
            discharging_reg <= 1'b0;
        end else begin
            mode_prev_reg   <= mode_sel;
            dis_timer_reg   <= dis_timer_next;
            discharging_reg <= dis_trigger || (dis_timer_reg != '0);
        end
    end

    // ------------------------------------------------------------------------
    // mode decode and detection
    // ------------------------------------------------------------------------
    charging_port_pkg::port_mode_type  mode;
    charging_port_pkg::dcp_state_type  dcp_state;
    logic                              dcp_power;
    logic                              data_on;
    logic                              power_on;
    logic                              enter_shorted;

    wire dcp_active = enable_eff && (mode == charging_port_pkg::MODE_DCP) && !discharging_reg;

    mode_decode u_mode_decode (
        .i_enable    (enable_eff),
        .i_mode_sel  (mode_sel),
        .i_discharge (discharging_reg),
        .i_dcp_power (dcp_power),
        .o_mode      (mode),
        .o_data_on   (data_on),
        .o_power_on  (power_on)
    );

    dcp_auto_fsm #(
        .ONE_V2_CYCLES (ONE_V2_CYCLES)
    ) u_dcp_auto_fsm (
        .i_core_clk      (i_core_clk),
        .i_rst_n         (rst_n_reg),
        .i_active        (dcp_active),
        .i_short_detect  (pins.short_detect),
        .i_line_held     (pins.line_held),
        .o_state         (dcp_state),
        .o_power_on      (dcp_power),
        .o_enter_shorted (enter_shorted)
    );

    // ------------------------------------------------------------------------
    // line bias of the active charging scheme
    // ------------------------------------------------------------------------
    wire bias_divider = dcp_active && (dcp_state == charging_port_pkg::DCP_DIVIDER);
    wire bias_1v2     = dcp_active && (dcp_state == charging_port_pkg::DCP_ONE_V2);
    wire bias_short   = dcp_active && (dcp_state != charging_port_pkg::DCP_DIVIDER);

    // ------------------------------------------------------------------------
    // switch outputs
    // ------------------------------------------------------------------------
    // current limit is not an input here on purpose: the switches ride through it
    // pattern 111 leaves the data path closed while the cdp handshake runs
    charging_port_pkg::switch_out_type sw_next;
    charging_port_pkg::switch_out_type sw_reg;

    assign sw_next.power_on      = power_on;
    assign sw_next.data_on       = data_on;
    assign sw_next.discharge     = discharging_reg;
    assign sw_next.divider_drive = bias_divider;
    assign sw_next.lines_short   = bias_short;
    assign sw_next.pullup_1v2    = bias_1v2;

    always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sw_reg <= '0;
        end else begin
            sw_reg <= sw_next;
        end
    end

    assign o_switches = sw_reg;

    // ------------------------------------------------------------------------
    // control and counter registers
    // ------------------------------------------------------------------------
    // an entry into shorted mode in the clearing cycle still counts
    always_comb begin
        short_count_next = short_count_reg;
        if (wr_count) begin
            short_count_next = 16'h0000;
        end
        if (enter_shorted) begin
            short_count_next = wr_count ? 16'h0001 : short_count_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg        <= `CTRL_RESET;
            short_count_reg <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_wdata[`CTRL_WIDTH-1:0];
            end
            short_count_reg <= short_count_next;
        end
    end

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] rdata_next;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STAT_MODE_LSB +: 3]  = mode_sel;
        status_word[`STAT_ENABLE_BIT]     = enable_eff;
        status_word[`STAT_CLIMIT_BIT]     = pins.current_limit;
        status_word[`STAT_DATA_ON_BIT]    = sw_reg.data_on;
        status_word[`STAT_POWER_ON_BIT]   = sw_reg.power_on;
        status_word[`STAT_DISCHARGE_BIT]  = sw_reg.discharge;
        status_word[`STAT_DCP_LSB +: 2]   = dcp_state;
    end

    // unmapped addresses read as zero
    assign rdata_next = !i_rd     ? 32'h0000_0000 :
                        hit_ctrl  ? {27'h000_0000, ctrl_reg} :
                        hit_stat  ? status_word :
                        hit_count ? {16'h0000, short_count_reg} : 32'h0000_0000;

    always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

endmodule : charging_port_ctrl

/* sim/charging_port_props.sv */
// checker bound to the charging port mode control
`timescale 1ns/1ps
module charging_port_props #(
    parameter int unsigned ONE_V2_CYCLES = 8
) (
    input wire logic                              i_core_clk,
    input wire logic                              i_reset_n,
    input wire logic                              i_wr,
    input wire logic                              i_rd,
    input wire logic [31:0]                       o_rdata,
    input wire charging_port_pkg::pin_in_type     i_pins,
    input wire charging_port_pkg::switch_out_type o_switches
);
    // ------------------------
    // helper logic
    // ------------------------
    logic [12:0] run_reg;
    // length of the current pull-up run, so a short or long 1.2 V phase shows up
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_reg <= 13'h0000;
        end else begin
            run_reg <= o_switches.pullup_1v2 ? run_reg + 13'h0001 : 13'h0000;
        end
    end
    // ------------------------
    // properties
    // ------------------------
    // pins reach the outputs three edges late, so pin levels are held four samples first
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    property p_dcp_data; (!i_pins.mode_sel[2])[*4] |-> !o_switches.data_on; endproperty
    a_dcp_data: assert property (p_dcp_data) else $error("data switch closed in dedicated mode");
    property p_en_low; (!i_pins.enable)[*4] |-> !o_switches.data_on; endproperty
    a_en_low: assert property (p_en_low) else $error("data switch closed with enable low");
    property p_client; (i_pins.mode_sel[2:1] == 2'b10)[*4] |-> !o_switches.power_on; endproperty
    a_client: assert property (p_client) else $error("port power on in client mode");
    property p_dis; o_switches.discharge |-> !o_switches.data_on && !o_switches.power_on; endproperty
    a_dis: assert property (p_dis) else $error("switch closed during discharge");
    property p_run; $fell(o_switches.pullup_1v2) && o_switches.lines_short |-> run_reg == 13'(ONE_V2_CYCLES); endproperty
    a_run: assert property (p_run) else $error("pull-up phase of wrong length");
    property p_rel; o_switches.lines_short && !o_switches.pullup_1v2 && $fell(i_pins.line_held)
        |-> ##[1:5] !o_switches.lines_short; endproperty
    a_rel: assert property (p_rel) else $error("shorted state kept after line release");
    property p_quiet; $changed(i_pins.mode_sel) && i_pins.mode_sel[2:1] == 2'b11 && $past(i_pins.mode_sel[2:1]) == 2'b11
        && !o_switches.discharge && !i_wr |=> (!o_switches.discharge)[*6]; endproperty
    a_quiet: assert property (p_quiet) else $error("discharge on a quiet pattern swap");
    property p_pwr; $rose(o_switches.lines_short) |-> o_switches.power_on && !o_switches.discharge; endproperty
    a_pwr: assert property (p_pwr) else $error("power dropped on shorted detection");
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside the read slot");
endmodule : charging_port_props

bind charging_port_ctrl charging_port_props #(.ONE_V2_CYCLES(ONE_V2_CYCLES)) charging_port_props_i (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pins(i_pins), .o_switches(o_switches));

/* sim/portable_device_model.sv */
// portable device hanging on the port data lines
`timescale 1ns/1ps
module portable_device_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_attach,
    input  wire logic       i_shorted,
    input  wire logic [2:0] i_delay,
    output logic            o_short_detect,
    output logic            o_line_held
);
    logic [2:0] wait_reg;
    // a slow device answers late; a divider device never answers the shorted scheme
    always @(posedge i_core_clk) begin
        wait_reg <= !i_attach ? 3'h0 : (wait_reg == i_delay) ? wait_reg : wait_reg + 3'h1;
        o_short_detect <= i_attach && i_shorted && (wait_reg == i_delay);
        o_line_held <= i_attach && i_shorted; // unplugging releases the line
    end
endmodule : portable_device_model

/* sim/charging_port_ctrl_tb_top.sv */
// self-checking bench of the charging port mode control
`timescale 1ns/1ps
module charging_port_ctrl_tb_top;
    logic                              clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0, attach = 0, shorted = 0;
    logic [7:0]                        addr = 8'h00;
    logic [31:0]                       wdata = 32'h0000_0000, rdata, e;
    logic [2:0]                        dly = 3'h0;
    logic                              sd, lh;
    charging_port_pkg::pin_in_type     pins = 7'h78;
    charging_port_pkg::switch_out_type sw;
    logic [31:0]                       rd_q[$], sw_q[$];
    int                                bad_count = 0, compares = 0;
    always #20 clk = ~clk;
    // device lines come from the partner, the rest from the bench
    wire charging_port_pkg::pin_in_type pins_w = {pins.enable, pins.mode_sel, sd, lh, pins.current_limit};
    charging_port_ctrl #(.ONE_V2_CYCLES(8), .DISCHARGE_CYCLES(8)) charging_port_ctrl_i (.i_core_clk(clk),
        .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_pins(pins_w), .o_switches(sw));
    portable_device_model portable_device_model_i (.i_core_clk(clk), .i_attach(attach), .i_shorted(shorted),
        .i_delay(dly), .o_short_detect(sd), .o_line_held(lh));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // bus tasks leave a free edge so a strobe is never set twice in one step
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] x);
        rd_q.push_back(x);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(1);
    endtask : rreg
    // mask in bits 13:8, expected switch levels in bits 5:0
    task automatic exp_sw(input logic [5:0] m, input logic [5:0] v);
        sw_q.push_back({18'h0_0000, m, 2'b00, v});
    endtask : exp_sw
    task automatic results;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // results are read half a cycle after the edge that launches them
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) begin
            e = rd_q.pop_front();
            check(rdata, e);
        end
        if (sw_q.size() > 0) begin
            e = sw_q.pop_front();
            check(32'(sw & e[13:8]), 32'(e[5:0]));
        end
    end
    initial begin
        tick(3000);
        bad_count++;
        results();
    end
    initial begin
        int r;
        r = $urandom(66);
        tick(6);
        rst_n <= 1'b1;
        tick(4);
        rreg(8'h00, 32'h0000_0001);
        rreg(8'h10, 32'h0000_0000);
        // every pattern with a random current-limit level, then enable dropped
        for (int i = 0; i < 8; i++) begin
            pins.mode_sel <= 3'(i);
            pins.current_limit <= 1'($urandom);
            tick(16);
            exp_sw(6'h38, i < 4 ? 6'h20 : i < 6 ? 6'h10 : 6'h30);
            pins.enable <= 1'b0;
            tick(4);
            exp_sw(6'h10, 6'h00);
            pins.enable <= 1'b1;
        end
        tick(16);
        pins.current_limit <= 1'b0;
        pins.mode_sel <= 3'b110;
        repeat (3) begin
            tick(2);
            exp_sw(6'h38, 6'h30);
        end
        pins.mode_sel <= 3'b100;
        tick(16);
        pins.mode_sel <= 3'b110;
        tick(6);
        exp_sw(6'h38, 6'h08);
        tick(16);
        wreg(8'h00, 32'h0000_0021);
        tick(3);
        exp_sw(6'h38, 6'h08);
        tick(16);
        rreg(8'h00, 32'h0000_0001);
        wreg(8'h00, 32'h0000_0013);
        tick(16);
        rreg(8'h04, 32'h0000_002C);
        wreg(8'h00, 32'h0000_0001);
        pins.mode_sel <= 3'b000;
        tick(16);
        exp_sw(6'h27, 6'h24);
        attach <= 1'b1;
        tick(20);
        exp_sw(6'h27, 6'h24);
        attach <= 1'b0;
        tick(2);
        shorted <= 1'b1;
        dly <= 3'($urandom);
        attach <= 1'b1;
        for (int n = 0; n < 40 && sw.lines_short !== 1'b1; n++) tick(1);
        tick(12);
        exp_sw(6'h3F, 6'h22);
        tick(20);
        exp_sw(6'h3F, 6'h22);
        rreg(8'h08, 32'h0000_0001);
        attach <= 1'b0;
        tick(6);
        exp_sw(6'h27, 6'h24);
        tick(2);
        results();
    end
endmodule : charging_port_ctrl_tb_top
